/* File: hdl/rscp_cfg.svh */
// rscp_cfg.svh: constants of the radio serial configuration port
// assumes: included by bare name by the package and both ends
`ifndef RSCP_CFG_SVH
`define RSCP_CFG_SVH
// ***********************************
// header byte fields
// ***********************************
`define RSCP_HDR_RW_BIT     7
`define RSCP_HDR_BURST_BIT  6
`define RSCP_ADDR_W         6
// ***********************************
// status byte fields
// ***********************************
`define RSCP_ST_RDY_BIT     7
`define RSCP_ST_STATE_HI    6
`define RSCP_ST_STATE_LO    4
`define RSCP_ST_CNT_HI      3
`define RSCP_ST_CNT_LO      0
`define RSCP_CNT_SAT        8'h0F
// ***********************************
// timing and software map of the master end
// ***********************************
`define RSCP_CLK_MHZ        200
`define RSCP_SCLK_DIV       16
`define RSCP_GAP_NS         100
`define RSCP_GAP_CYC        ((`RSCP_GAP_NS * `RSCP_CLK_MHZ + 999) / 1000)
`define RSCP_REG_CTRL       4'h0
`define RSCP_REG_TXDATA     4'h1
`define RSCP_REG_RXDATA     4'h2
`define RSCP_REG_STAT       4'h3
`define RSCP_REG_IRQ_ST     4'h4
`define RSCP_REG_IRQ_MASK   4'h5
`define RSCP_REG_DEVSTAT    4'h6
`endif

/* File: hdl/rscp_pkg.sv */
// rscp_pkg.sv: shared types of both ends
// assumes: rscp_cfg.svh on the include path
`default_nettype none
`include "rscp_cfg.svh"
package rscp_pkg;
	// main state code shown in the status byte
	typedef enum logic [2:0] {
		RSCP_IDLE = 3'h0, RSCP_RX = 3'h1, RSCP_TX = 3'h2, RSCP_SYNTH_READY_TX = 3'h3,
		RSCP_CALIBRATE = 3'h4, RSCP_SETTLING = 3'h5, RSCP_RX_OVERFLOW = 3'h6,
		RSCP_TX_UNDERFLOW = 3'h7
	} rscp_state_type;
	typedef logic [`RSCP_ADDR_W-1:0] rscp_addr_type;
endpackage : rscp_pkg
`default_nettype wire

/* File: hdl/rscp_if.sv */
// rscp_if.sv: the four serial wires between master and device
// assumes: the bench joins both ends through this interface
`default_nettype none
interface rscp_if;
	logic select_n;    // chip select, active low, master driven
	logic sclk;        // serial clock, master driven
	logic si;          // serial data into device
	logic so;          // serial data out of device
	logic so_oe;       // device drives so while high
	logic so_wire;     // resolved so level, pulled high when released
	assign so_wire = so_oe ? so : 1'b1;
	modport device (input select_n, input sclk, input si, output so, output so_oe);
	modport master (output select_n, output sclk, output si, input so_wire);
endinterface : rscp_if
`default_nettype wire

/* File: hdl/rscp_device.sv */
// rscp_device.sv: slave end of the serial configuration port
// assumes: link pins are asynchronous to clock; the core supplies status and
// takes decoded header and data bytes on one-cycle strobes
//
// Contract
// (R01) device is slave of four-wire port
// (R02) bits shift most significant first
// (R03) header: rw, burst, six-bit address
// (R04) master holds select low whole access
// (R05) select rising aborts, partial byte dropped
// (R06) master waits for so low first
// (R07) ready only with regulator and oscillator
// (R08) ready at once unless sleep, oscillator-off, reset
// (R09) no gap: serial clock at most 9 MHz
// (R10) 100 ns pause allows faster clock
// (R11) status byte shifted out during every byte
// (R12) three-bit state field encoding as listed
// (R13) count field saturates at fifteen
// (R14) sample rising edge, shift on falling
`default_nettype none
`include "rscp_cfg.svh"
module rscp_device (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   clk_en,
	// link
	rscp_if.device                      link,
	// core status
	input  wire logic                   regulator_ok,
	input  wire logic                   osc_running,
	input  wire logic                   sleep_state,
	input  wire logic                   oscillator_off_state,
	input  wire logic                   soft_reset_strobe,
	input  wire rscp_pkg::rscp_state_type main_state,
	input  wire logic [6:0]             rx_bytes,
	input  wire logic [6:0]             tx_free,
	// decoded access
	output logic                        hdr_valid,
	output logic                        hdr_read,
	output logic                        hdr_burst,
	output rscp_pkg::rscp_addr_type     hdr_addr,
	output logic                        data_valid,
	output logic [7:0]                  data_byte,
	output logic                        abort_pulse
);
	import rscp_pkg::*;

	typedef struct packed {
		logic [1:0] cs_sync;
		logic [1:0] ck_sync;
		logic [1:0] si_sync;
		logic       ck_last;
		logic       rst_pend;
		logic       active;
		logic       in_hdr;
		logic       rd;
		logic [2:0] bitcnt;
		logic [7:0] shin;
		logic [7:0] shout;
		logic       so_oe;
		logic       hv;
		logic       hr;
		logic       hb;
		rscp_addr_type ha;
		logic       dv;
		logic [7:0] db;
		logic       ab;
	} rscp_dev_type;

	rscp_dev_type st_reg;
	rscp_dev_type st_next;

	logic       ready;
	logic [3:0] cnt_sat;
	logic [7:0] status;

	// ***********************************
	// status byte
	// ***********************************
	always_comb begin
		ready = regulator_ok && osc_running && !sleep_state           // (R07)
			&& !oscillator_off_state && !st_reg.rst_pend;             // (R08)
		// count depends on the direction of the last header decoded
		if (st_reg.rd) begin
			cnt_sat = (rx_bytes >= 7'(`RSCP_CNT_SAT)) ? 4'hF : rx_bytes[3:0]; // (R13)
		end else begin
			cnt_sat = (tx_free >= 7'(`RSCP_CNT_SAT)) ? 4'hF : tx_free[3:0];   // (R13)
		end
		status = {!ready, main_state, cnt_sat};                       // (R11) (R12)
	end

	// ***********************************
	// shift engine
	// ***********************************
	always_comb begin
		logic sel;
		logic ck_rise;
		logic ck_fall;
		logic [7:0] nb;
		st_next = st_reg;
		sel = !st_reg.cs_sync[1];
		ck_rise = st_reg.ck_sync[1] && !st_reg.ck_last;
		ck_fall = !st_reg.ck_sync[1] && st_reg.ck_last;
		nb = {st_reg.shin[6:0], st_reg.si_sync[1]};                   // (R02)
		st_next.cs_sync = {st_reg.cs_sync[0], link.select_n};
		st_next.ck_sync = {st_reg.ck_sync[0], link.sclk};
		st_next.si_sync = {st_reg.si_sync[0], link.si};
		st_next.ck_last = st_reg.ck_sync[1];
		st_next.hv = 1'b0;
		st_next.dv = 1'b0;
		st_next.ab = 1'b0;
		// soft reset holds off ready until the next select
		if (soft_reset_strobe) begin
			st_next.rst_pend = 1'b1;                                  // (R08)
		end
		if (!sel) begin
			// select high: drop any partial byte
			if (st_reg.active && (st_reg.bitcnt != 3'h0 || !st_reg.in_hdr)) begin
				st_next.ab = st_reg.bitcnt != 3'h0;                   // (R05)
			end
			st_next.active = 1'b0;
			st_next.so_oe = 1'b0;
			st_next.bitcnt = 3'h0;
			st_next.in_hdr = 1'b1;
			if (!soft_reset_strobe) begin
				st_next.rst_pend = 1'b0;
			end
		end else if (!st_reg.active) begin
			// wait for ready, then drive ready low and load the status byte
			st_next.so_oe = 1'b1;                                     // (R01)
			st_next.shout = status;
			if (ready) begin
				st_next.active = 1'b1;                                // (R07)
				st_next.in_hdr = 1'b1;
			end
		end else begin
			if (ck_rise) begin
				st_next.shin = nb;                                    // (R14)
				st_next.bitcnt = st_reg.bitcnt + 3'h1;
				if (st_reg.bitcnt == 3'h7) begin
					if (st_reg.in_hdr) begin
						st_next.hv = 1'b1;                            // (R03)
						st_next.hr = nb[`RSCP_HDR_RW_BIT];
						st_next.hb = nb[`RSCP_HDR_BURST_BIT];
						st_next.ha = nb[`RSCP_ADDR_W-1:0];
						st_next.rd = nb[`RSCP_HDR_RW_BIT];
						st_next.in_hdr = 1'b0;
					end else begin
						st_next.dv = 1'b1;
						st_next.db = nb;
					end
				end
			end
			if (ck_fall) begin
				// byte boundary reloads fresh status, else shift
				if (st_reg.bitcnt == 3'h0) begin
					st_next.shout = status;                           // (R11)
				end else begin
					st_next.shout = {st_reg.shout[6:0], 1'b0};        // (R14)
				end
			end
		end
		// soft reset while selected drops the access at once, so so goes back
		// high and the pending flag keeps it there until select is released
		if (sel && soft_reset_strobe) begin
			st_next.active = 1'b0;                                    // (R08)
			st_next.bitcnt = 3'h0;
			st_next.in_hdr = 1'b1;
		end
	end

	// ***********************************
	// state register
	// ***********************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.cs_sync <= 2'h3;
			st_reg.in_hdr <= 1'b1;
			st_reg.shout <= 8'h80;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// outputs; so reads high (not ready) until active
	assign link.so = st_reg.active ? st_reg.shout[7] : 1'b1;         // (R06)
	assign link.so_oe = st_reg.so_oe;
	assign hdr_valid = st_reg.hv;
	assign hdr_read = st_reg.hr;
	assign hdr_burst = st_reg.hb;
	assign hdr_addr = st_reg.ha;
	assign data_valid = st_reg.dv;
	assign data_byte = st_reg.db;
	assign abort_pulse = st_reg.ab;
endmodule : rscp_device
`default_nettype wire

/* File: hdl/rscp_master.sv */
// rscp_master.sv: master end, software drives it through a small register port
// assumes: so arrives asynchronously; sclk is made here by a divider
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none
`include "rscp_cfg.svh"
module rscp_master (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// link
	rscp_if.master           link,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [7:0]       rdata,
	// interrupt
	output logic             irq
);
	import rscp_pkg::*;

	typedef enum {M_IDLE, M_WAIT_RDY, M_LOW, M_HIGH, M_GAP} rscp_mst_fsm_type;

	typedef struct packed {
		logic [1:0]  so_sync;
		rscp_mst_fsm_type fsm;
		logic        sel_n;
		logic        sck;
		logic [7:0]  sh_out;
		logic [7:0]  sh_in;
		logic [2:0]  bitcnt;
		logic [7:0]  div;
		logic [7:0]  txd;
		logic        tx_full;
		logic        hold;
		logic [7:0]  rxd;
		logic [7:0]  devstat;
		logic [1:0]  irq_st;
		logic [1:0]  irq_mask;
		logic [7:0]  rdata;
	} rscp_mst_type;

	rscp_mst_type st_reg;
	rscp_mst_type st_next;

	// ***********************************
	// control and link sequencing
	// ***********************************
	always_comb begin
		logic byte_done;
		logic sel_drop;
		st_next = st_reg;
		byte_done = 1'b0;
		sel_drop = 1'b0;
		st_next.so_sync = {st_reg.so_sync[0], link.so_wire};
		// register writes: a txdata write starts, ctrl bit1 keeps select low after byte
		if (wr) begin
			case (addr)
				`RSCP_REG_CTRL: begin
					st_next.hold = wdata[1];
					if (!wdata[1] && st_reg.fsm == M_GAP) begin
						sel_drop = 1'b1;
					end
				end
				`RSCP_REG_TXDATA: begin
					st_next.txd = wdata;
					st_next.tx_full = 1'b1;
				end
				`RSCP_REG_IRQ_MASK: st_next.irq_mask = wdata[1:0];
				default: ;
			endcase
		end
		case (st_reg.fsm)
			M_IDLE: begin
				st_next.sel_n = 1'b1;
				if (st_reg.tx_full) begin
					st_next.sel_n = 1'b0;                             // (R04)
					st_next.fsm = M_WAIT_RDY;
				end
			end
			M_WAIT_RDY: begin
				if (!st_reg.so_sync[1]) begin                         // (R06)
					st_next.sh_out = st_reg.txd;
					st_next.tx_full = 1'b0;
					st_next.fsm = M_LOW;
					st_next.div = 8'h0;
				end
			end
			M_LOW: begin
				st_next.div = st_reg.div + 8'h1;
				if (st_reg.div == 8'(`RSCP_SCLK_DIV / 2 - 1)) begin
					st_next.sck = 1'b1;                               // (R14)
					st_next.sh_in = {st_reg.sh_in[6:0], st_reg.so_sync[1]}; // (R02)
					st_next.div = 8'h0;
					st_next.fsm = M_HIGH;
				end
			end
			M_HIGH: begin
				st_next.div = st_reg.div + 8'h1;
				if (st_reg.div == 8'(`RSCP_SCLK_DIV / 2 - 1)) begin
					st_next.sck = 1'b0;
					st_next.div = 8'h0;
					st_next.bitcnt = st_reg.bitcnt + 3'h1;
					st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};      // (R02)
					if (st_reg.bitcnt == 3'h7) begin
						byte_done = 1'b1;
						st_next.fsm = M_GAP;
					end else begin
						st_next.fsm = M_LOW;
					end
				end
			end
			M_GAP: begin
				// pause between bytes keeps device timing safe
				if (st_reg.div != 8'(`RSCP_GAP_CYC)) begin            // (R09)
					st_next.div = st_reg.div + 8'h1;                  // (R10)
				end else if (!st_reg.hold) begin
					st_next.sel_n = 1'b1;
					st_next.fsm = M_IDLE;
				end else if (st_reg.tx_full) begin
					st_next.sh_out = st_reg.txd;
					st_next.tx_full = 1'b0;
					st_next.div = 8'h0;
					st_next.fsm = M_LOW;                              // (R04)
				end
				if (sel_drop) begin
					st_next.sel_n = 1'b1;
					st_next.fsm = M_IDLE;
				end
			end
			default: st_next.fsm = M_IDLE;
		endcase
		if (byte_done) begin
			st_next.rxd = st_reg.sh_in;
			st_next.devstat = st_reg.sh_in;
		end
		// irq: bit0 byte done, bit1 device not ready reported; set beats clear
		if (wr && addr == `RSCP_REG_IRQ_ST) begin
			st_next.irq_st = st_reg.irq_st & ~wdata[1:0];
		end
		if (byte_done) begin
			st_next.irq_st[0] = 1'b1;
			if (st_reg.sh_in[7]) begin
				st_next.irq_st[1] = 1'b1;
			end
		end
		st_next.rdata = 8'h00;
		if (rd) begin
			case (addr)
				`RSCP_REG_CTRL:     st_next.rdata = {6'h0, st_reg.hold, 1'b0};
				`RSCP_REG_RXDATA:   st_next.rdata = st_reg.rxd;
				// a held access parked after its pause waits for software, not busy
				`RSCP_REG_STAT:     st_next.rdata = {6'h0, st_reg.tx_full,
					st_reg.fsm != M_IDLE && !(st_reg.fsm == M_GAP
					&& st_reg.div == 8'(`RSCP_GAP_CYC))};
				`RSCP_REG_IRQ_ST:   st_next.rdata = {6'h0, st_reg.irq_st};
				`RSCP_REG_IRQ_MASK: st_next.rdata = {6'h0, st_reg.irq_mask};
				`RSCP_REG_DEVSTAT:  st_next.rdata = st_reg.devstat;
				default:            st_next.rdata = 8'h00;
			endcase
		end
	end

	// ***********************************
	// state register
	// ***********************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.so_sync <= 2'h3;
			st_reg.sel_n <= 1'b1;
			st_reg.fsm <= M_IDLE;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign link.select_n = st_reg.sel_n;
	assign link.sclk = st_reg.sck;
	assign link.si = st_reg.sh_out[7];
	assign rdata = st_reg.rdata;
	assign irq = |(st_reg.irq_st & st_reg.irq_mask);
endmodule : rscp_master
`default_nettype wire

/* File: verification/rscp_link_monitor.sv */
// rscp_link_monitor.sv: wire-level checks of the serial link between master and device
// assumes: the bench instantiates it beside the link and passes the wires as plain inputs
`default_nettype none
`include "rscp_cfg.svh"
module rscp_link_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// link wires
	input wire logic select_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_wire
);
	localparam int GAP = `RSCP_GAP_CYC;
	// ************************************
	// helper state
	// ************************************
	logic [2:0] bits_reg;  // rising edges of this access, modulo a byte
	logic       seen_reg;  // at least one bit sent since select fell
	logic       rdy_reg;   // so was seen low since select fell
	logic       sclk_reg;
	logic [7:0] low_reg;   // cycles sclk has stayed low, saturating
	// edge finding on the sampled clock; bit count and both flags cleared whenever select is released
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bits_reg <= 3'h0;
			seen_reg <= 1'h0;
			rdy_reg <= 1'h0;
			sclk_reg <= 1'h0;
			low_reg <= 8'h00;
		end else begin
			sclk_reg <= sclk;
			low_reg <= sclk ? 8'h00 : (low_reg == 8'hFF ? low_reg : low_reg + 8'h01);
			if (select_n) begin
				bits_reg <= 3'h0;
				seen_reg <= 1'h0;
				rdy_reg <= 1'h0;
			end else begin
				if (!so_wire) rdy_reg <= 1'h1;
				if (sclk && !sclk_reg) begin
					bits_reg <= bits_reg + 3'h1;
					seen_reg <= 1'h1;
				end
			end
		end
	end
	// ************************************
	// assertions
	// ************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	chk_oe_on_select: assert property ($fell(select_n) |-> ##[1:6] so_oe)
		else $error("device did not take so after select fell");
	chk_so_release: assert property ($rose(select_n) |-> ##[1:6] !so_oe)
		else $error("device kept so after select rose");
	chk_sclk_selected: assert property ($rose(sclk) |-> !select_n)
		else $error("sclk rose while deselected");
	chk_ready_first: assert property ($rose(sclk) |-> rdy_reg)
		else $error("sclk rose before so went low");
	chk_si_stable: assert property ($changed(si) |-> !sclk)
		else $error("si changed while sclk high");
	chk_so_stable: assert property ((so_oe && $past(so_oe) && $changed(so)) |-> !sclk)
		else $error("so changed while sclk high");
	chk_sclk_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("sclk high phase not eight cycles");
	// a faster clock than the no-gap limit is only safe with the pause between bytes
	chk_byte_gap: assert property (($rose(sclk) && seen_reg && bits_reg == 3'h0) |-> low_reg >= GAP)
		else $error("pause between bytes too short");
	cov_two_bytes: cover property ($rose(sclk) && seen_reg && bits_reg == 3'h0);
	cov_ready: cover property (!select_n && $fell(so_wire));
	cov_release: cover property ($rose(select_n) && seen_reg);
endmodule : rscp_link_monitor
`default_nettype wire

/* File: verification/tb.sv */
// tb.sv: both ends joined over the link, a spare device driven by hand, master and first device checked
// against a byte-level model; assumes the package, interface and both ends compiled first
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rscp_pkg::*;
	// ************************************
	// signals and instances
	// ************************************
	logic clock = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, irq;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, data_byte;
	logic regulator_ok = 1'h1, osc_running = 1'h1, sleep_state = 1'h0, oscillator_off_state = 1'h0;
	logic soft_reset_strobe = 1'h0, hdr_valid, hdr_read, hdr_burst, data_valid, hdr_valid2, abort2;
	rscp_state_type main_state = RSCP_IDLE;
	rscp_addr_type hdr_addr;
	logic [6:0] rx_bytes = 7'h00, tx_free = 7'h00;
	logic s2_sel_n = 1'h1, s2_sclk = 1'h0, s2_si = 1'h0;
	int num_errors = 0, num_checks = 0, aborts = 0, hdrs2 = 0;
	logic [7:0] hq[$], dq[$];
	rscp_if link();
	rscp_if link2();
	rscp_master rscp_master_i (.clock(clock), .nrst(nrst), .clk_en(1'h1), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	rscp_device rscp_device_i (.clock(clock), .nrst(nrst), .clk_en(1'h1), .link(link),
		.regulator_ok(regulator_ok), .osc_running(osc_running), .sleep_state(sleep_state),
		.oscillator_off_state(oscillator_off_state), .soft_reset_strobe(soft_reset_strobe),
		.main_state(main_state), .rx_bytes(rx_bytes), .tx_free(tx_free), .hdr_valid(hdr_valid),
		.hdr_read(hdr_read), .hdr_burst(hdr_burst), .hdr_addr(hdr_addr),
		.data_valid(data_valid), .data_byte(data_byte), .abort_pulse());
	rscp_device rscp_device_i2 (.clock(clock), .nrst(nrst), .clk_en(1'h1), .link(link2),
		.regulator_ok(regulator_ok), .osc_running(osc_running), .sleep_state(sleep_state),
		.oscillator_off_state(oscillator_off_state), .soft_reset_strobe(soft_reset_strobe),
		.main_state(main_state), .rx_bytes(rx_bytes), .tx_free(tx_free), .hdr_valid(hdr_valid2),
		.hdr_read(), .hdr_burst(), .hdr_addr(), .data_valid(), .data_byte(), .abort_pulse(abort2));
	rscp_link_monitor rscp_link_monitor_i (.clock(clock), .nrst(nrst), .select_n(link.select_n),
		.sclk(link.sclk), .si(link.si), .so(link.so), .so_oe(link.so_oe), .so_wire(link.so_wire));
	// the spare link stands in for a master that breaks the rules on purpose
	assign link2.select_n = s2_sel_n;
	assign link2.sclk = s2_sclk;
	assign link2.si = s2_si;
	always #2.5 clock = ~clock;
	// collect what the devices decoded, in order
	always @(posedge clock) begin
		if (hdr_valid === 1'h1) hq.push_back({hdr_read, hdr_burst, hdr_addr});
		if (data_valid === 1'h1) dq.push_back(data_byte);
		if (abort2 === 1'h1) aborts++;
		if (hdr_valid2 === 1'h1) hdrs2++;
	end
	// ************************************
	// tasks
	// ************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic wait_idle();
		logic [7:0] v;
		int n;
		n = 0;
		v = 8'h03;
		while (v[1:0] != 2'h0 && n < 500) begin
			rd_reg(4'h3, v);
			n++;
		end
		if (n == 500) chk("busy", 8'h00, v);
	endtask : wait_idle
	// expected status byte: ready low, state, count saturating at fifteen
	function automatic logic [7:0] model_st(input logic rw);
		int c;
		c = rw ? rx_bytes : tx_free;
		if (c > 15) c = 15;
		return {1'h0, main_state, c[3:0]};
	endfunction : model_st
	// header and one data byte under hold, then the access is closed in the pause
	task automatic xfer(input logic [7:0] h, input logic [7:0] d);
		logic [7:0] v;
		wr_reg(4'h0, 8'h02);
		wr_reg(4'h1, h);
		wait_idle();
		rd_reg(4'h2, v);
		chk("header status", {1'h0, main_state, 4'h0}, {v[7:4], 4'h0});
		wr_reg(4'h1, d);
		wait_idle();
		rd_reg(4'h2, v);
		chk("data status", model_st(h[7]), v);
		wr_reg(4'h0, 8'h00);
		repeat (40) @(posedge clock);
		chk("select", 8'h01, {7'h00, link.select_n});
		chk("header", h, hq.pop_front());
		chk("data", d, dq.pop_front());
	endtask : xfer
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	// ************************************
	// tests
	// ************************************
	initial begin
		logic [7:0] v, h;
		void'($urandom(50));
		repeat (6) @(posedge clock);
		nrst <= 1'h1;
		@(posedge clock);
		#1 chk("so idle", 8'h01, {7'h00, link.so_wire});
		chk("irq idle", 8'h00, {7'h00, irq});
		$display("test reset done");
		// every state code, counts around saturation, reads and writes in turn
		for (int i = 0; i < 8; i++) begin
			main_state <= rscp_state_type'(3'(i));
			rx_bytes <= (i < 3) ? 7'h0E + 7'(i) : 7'($urandom);
			tx_free <= (i < 3) ? 7'h10 - 7'(i) : 7'($urandom);
			h = 8'($urandom);
			h[7] = i[0];
			xfer(h, 8'($urandom));
		end
		$display("test transfers done");
		// interrupt raised, masked, cleared; unmapped read gives zero
		rd_reg(4'h4, v);
		chk("irq status", 8'h01, {7'h00, v[0]});
		chk("irq masked", 8'h00, {7'h00, irq});
		wr_reg(4'h5, 8'h01);
		@(posedge clock);
		#1 chk("irq", 8'h01, {7'h00, irq});
		wr_reg(4'h4, 8'h03);
		@(posedge clock);
		#1 chk("irq cleared", 8'h00, {7'h00, irq});
		wr_reg(4'h5, 8'h00);
		rd_reg(4'h4, v);
		chk("irq status cleared", 8'h00, v);
		rd_reg(4'hB, v);
		chk("unmapped", 8'h00, v);
		$display("test interrupt done");
		// regulator or oscillator not ready: so stays high and the header waits
		for (int j = 0; j < 2; j++) begin
			@(posedge clock);
			regulator_ok <= j[0];
			osc_running <= !j[0];
			wr_reg(4'h0, 8'h00);
			h = 8'($urandom);
			wr_reg(4'h1, h);
			repeat (60) @(posedge clock);
			chk("so not ready", 8'h01, {7'h00, link.so_wire});
			regulator_ok <= 1'h1;
			osc_running <= 1'h1;
			wait_idle();
			repeat (40) @(posedge clock);
			chk("late header", h, hq.pop_front());
		end
		$display("test not ready done");
		// spare link, 85 ns serial clock: select released after three bits
		s2_sel_n <= 1'h0;
		repeat (20) @(posedge clock);
		#1 chk("spare ready", 8'h00, {7'h00, link2.so_wire});
		repeat (3) begin
			@(posedge clock);
			s2_si <= 1'($urandom);
			repeat (8) @(posedge clock);
			s2_sclk <= 1'h1;
			repeat (8) @(posedge clock);
			s2_sclk <= 1'h0;
		end
		repeat (4) @(posedge clock);
		s2_sel_n <= 1'h1;
		repeat (20) @(posedge clock);
		#1 chk("abort", 8'h01, aborts[7:0]);
		chk("no header", 8'h00, hdrs2[7:0]);
		// sleep and oscillator off keep so high; soft reset while selected sends so back high
		for (int k = 0; k < 3; k++) begin
			@(posedge clock);
			sleep_state <= (k == 0);
			oscillator_off_state <= (k == 1);
			repeat (8) @(posedge clock);
			s2_sel_n <= 1'h0;
			if (k == 2) begin
				repeat (20) @(posedge clock);
				soft_reset_strobe <= 1'h1;
				@(posedge clock);
				soft_reset_strobe <= 1'h0;
			end
			repeat (20) @(posedge clock);
			#1 chk("spare held", 8'h01, {7'h00, link2.so_wire});
			@(posedge clock);
			s2_sel_n <= 1'h1;
			repeat (20) @(posedge clock);
		end
		$display("test spare link done");
		end_sim();
	end
	// the whole run takes well under a tenth of this
	initial begin
		#400000;
		num_errors++;
		$display("Error watchdog expected done seen hang");
		end_sim();
	end
endmodule : tb
`default_nettype wire
